// >>> lpt_pkg.sv
// lpt_pkg: constants and types of the line pattern table sequencer.
// assumes one clock of 25 MHz; one table entry count is one pixel period.
package lpt_pkg;
   localparam int lpt_tables = 9;
   localparam int lpt_entries = 10;
   localparam int lpt_count_w = 12;
   // entry word: count[19:8], hgate[6], pattern bits 6..1 at [5:0]
   localparam int lpt_hgate_pos = 6;
   localparam int lpt_count_lsb = 8;
   localparam int lpt_pixel_cycles = 1;
   // axi register offsets
   localparam logic [7:0] lpt_ctrl_off = 8'h00;
   localparam logic [7:0] lpt_overlap_off = 8'h04;
   localparam logic [7:0] lpt_status_off = 8'h08;
   localparam logic [31:0] lpt_ctrl_reset = 32'h00000000;
   localparam logic [7:0] lpt_overlap_reset = 8'h00;
   localparam logic [1:0] lpt_resp_okay = 2'h0;
   localparam logic [1:0] lpt_resp_slverr = 2'h2;
   typedef logic [19:0] lpt_entry_type;
   typedef enum logic [1:0]
   {
      lpt_idle = 2'h0,
      lpt_run = 2'h1,
      lpt_hold = 2'h2
   } lpt_state_type;
   // entry builder: count, gate, pattern bits 6..1
   function automatic lpt_entry_type lpt_e(input int c, input logic g,
      input logic [5:0] p);
      lpt_e = {c[11:0], 1'b0, g, p};
   endfunction : lpt_e
endpackage : lpt_pkg

// >>> lpt_rom_if.sv
// lpt_rom_if: table lookup between sequencer and table store.
// assumes one clock domain; lookup is combinational.
interface lpt_rom_if;
   import lpt_pkg::*;
   logic [3:0] table_sel;
   logic [3:0] entry_sel;
   lpt_entry_type entry;
   modport seq (output table_sel, output entry_sel, input entry);
   modport rom (input table_sel, input entry_sel, output entry);
endinterface : lpt_rom_if

// >>> lpt_rom.sv
// lpt_rom: default line pattern tables.
// assumes selects stay in range; anything else reads a terminating entry.
module lpt_rom
   import lpt_pkg::*;
(
   // lookup
   lpt_rom_if.rom rom
);
   lpt_entry_type entry;
   // pattern field bits: [5]=bit6 ... [0]=bit1
   always_comb
   begin
      entry = lpt_e(0, 1'b0, 6'h00);
      unique case ({rom.table_sel, rom.entry_sel})
         // line transfer
         8'h00: entry = lpt_e(1, 1'b0, 6'h00);
         8'h01: entry = lpt_e(1, 1'b0, 6'h04);
         8'h02: entry = lpt_e(30, 1'b0, 6'h0C);
         8'h03: entry = lpt_e(1, 1'b0, 6'h04);
         8'h04: entry = lpt_e(30, 1'b0, 6'h00);
         8'h05: entry = lpt_e(1, 1'b1, 6'h00);
         // photodiode transfer
         8'h10: entry = lpt_e(1, 1'b0, 6'h00);
         8'h11: entry = lpt_e(500, 1'b0, 6'h04);
         8'h12: entry = lpt_e(1, 1'b0, 6'h05);
         8'h13: entry = lpt_e(240, 1'b0, 6'h0D);
         8'h14: entry = lpt_e(1, 1'b0, 6'h05);
         8'h15: entry = lpt_e(400, 1'b0, 6'h04);
         8'h16: entry = lpt_e(1310, 1'b0, 6'h00);
         // integration
         8'h20: entry = lpt_e(1, 1'b1, 6'h00);
         // binning line transfer
         8'h30: entry = lpt_e(1, 1'b0, 6'h00);
         8'h31: entry = lpt_e(1, 1'b0, 6'h04);
         8'h32: entry = lpt_e(30, 1'b0, 6'h0C);
         8'h33: entry = lpt_e(1, 1'b0, 6'h04);
         8'h34: entry = lpt_e(30, 1'b0, 6'h00);
         8'h35: entry = lpt_e(1, 1'b0, 6'h04);
         8'h36: entry = lpt_e(30, 1'b0, 6'h0C);
         8'h37: entry = lpt_e(1, 1'b0, 6'h04);
         8'h38: entry = lpt_e(30, 1'b1, 6'h00);
         // flush
         8'h40: entry = lpt_e(1, 1'b0, 6'h20);
         8'h41: entry = lpt_e(1, 1'b0, 6'h24);
         8'h42: entry = lpt_e(198, 1'b0, 6'h2C);
         8'h43: entry = lpt_e(1, 1'b0, 6'h24);
         8'h44: entry = lpt_e(199, 1'b0, 6'h20);
         // idle integration
         8'h50: entry = lpt_e(1, 1'b0, 6'h00);
         // photodiode flush start
         8'h60: entry = lpt_e(1, 1'b0, 6'h00);
         8'h61: entry = lpt_e(25, 1'b0, 6'h04);
         8'h62: entry = lpt_e(1, 1'b0, 6'h05);
         8'h63: entry = lpt_e(25, 1'b0, 6'h0D);
         // photodiode flush end
         8'h70: entry = lpt_e(10, 1'b0, 6'h0D);
         8'h71: entry = lpt_e(10, 1'b0, 6'h05);
         8'h72: entry = lpt_e(25, 1'b0, 6'h04);
         8'h73: entry = lpt_e(2, 1'b0, 6'h00);
         // photodiode flush
         8'h80: entry = lpt_e(20, 1'b0, 6'h04);
         8'h81: entry = lpt_e(200, 1'b0, 6'h00);
         8'h82: entry = lpt_e(20, 1'b0, 6'h04);
         8'h83: entry = lpt_e(10, 1'b0, 6'h0C);
         8'h84: entry = lpt_e(1, 1'b0, 6'h0D);
         default: entry = lpt_e(0, 1'b0, 6'h00);
      endcase
   end
   assign rom.entry = entry;
endmodule : lpt_rom

// >>> lpt_seq.sv
// lpt_seq: line pattern sequencer with axi4-lite control.
// assumes trigger arrives asynchronously; bus master on same clock.
module lpt_seq
   import lpt_pkg::*;
(
   // clock, reset, enable
   input wire logic clock,
   input wire logic reset,
   input wire logic clock_enable,
   // external trigger
   input wire logic integration_done_trigger,
   // axi4-lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // sensor pattern outputs
   output logic [6:1] pattern_bit,
   output logic horizontal_gate,
   output logic horizontal_binning,
   output logic line_done
);
   typedef struct packed
   {
      logic [1:0] trig_sync;
      lpt_state_type state;
      logic [3:0] table_sel;
      logic [3:0] entry_sel;
      logic [lpt_count_w-1:0] count;
      logic [31:0] ctrl;
      logic [7:0] overlap;
      logic [7:0] ovl_count;
      logic [6:1] pattern;
      logic hgate;
      logic binning;
      logic done;
      logic trig_seen;
      logic aw_got;
      logic w_got;
      logic awready;
      logic wready;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } lpt_regs_type;

   lpt_regs_type r;
   lpt_regs_type next_r;
   lpt_rom_if rom_bus ();
   lpt_entry_type cur;
   logic [31:0] wmask;
   logic trig;

   lpt_rom u_rom (.rom(rom_bus));
   assign rom_bus.table_sel = r.table_sel;
   assign rom_bus.entry_sel = r.entry_sel;
   assign cur = rom_bus.entry;
   assign trig = r.trig_sync[1];

   always_comb
   begin
      next_r = r;
      next_r.trig_sync = {r.trig_sync[0], integration_done_trigger};
      next_r.done = 1'b0;
      // trigger latched; set wins over the clear at table restart
      if (trig)
         next_r.trig_seen = 1'b1;
      // sequencer
      unique case (r.state)
         lpt_idle:
         begin
            next_r.pattern = '0;
            next_r.hgate = 1'b0;
            if (r.ctrl[0])
            begin
               next_r.table_sel = r.ctrl[7:4];
               next_r.entry_sel = 4'h0;
               next_r.count = '0;
               next_r.trig_seen = trig;
               next_r.state = lpt_run;
            end
         end
         lpt_run:
         begin
            // load entry; zero count ends the table
            if (cur[lpt_count_lsb +: lpt_count_w] == '0)
            begin
               next_r.done = 1'b1;
               next_r.entry_sel = 4'h0;
               next_r.binning = 1'b0;
               // integration repeats until trigger
               if (r.table_sel == 4'h2 && !r.trig_seen && !trig)
                  next_r.state = lpt_run;
               else if (r.ctrl[1] && r.table_sel != 4'h2)
                  next_r.state = lpt_run;
               else
                  next_r.state = lpt_idle;
               next_r.trig_seen = trig;
               if (!r.ctrl[0])
                  next_r.state = lpt_idle;
               // a finished table drops start so idle does not rerun it
               if (next_r.state == lpt_idle)
                  next_r.ctrl[0] = 1'b0;
            end
            else
            begin
               next_r.count = cur[lpt_count_lsb +: lpt_count_w];
               next_r.hgate = cur[lpt_hgate_pos];
               // binning readout follows binning transfer
               next_r.binning = (r.table_sel == 4'h3) &&
                  cur[lpt_hgate_pos];
               // phase two waits overlap cycles after phase one
               next_r.pattern = {cur[5:3], r.pattern[3], cur[1:0]};
               next_r.ovl_count = r.overlap;
               if (r.overlap == 8'h00)
                  next_r.pattern[3] = cur[2];
               next_r.state = lpt_hold;
            end
         end
         lpt_hold:
         begin
            if (r.ovl_count > 8'h01)
               next_r.ovl_count = r.ovl_count - 8'h01;
            else
            begin
               next_r.ovl_count = 8'h00;
               next_r.pattern[3] = cur[2];
            end
            // hold entry for its pixel count
            if (r.count <= lpt_count_w'(lpt_pixel_cycles))
            begin
               next_r.pattern[3] = cur[2];
               next_r.entry_sel = r.entry_sel + 4'h1;
               next_r.state = lpt_run;
            end
            else
               next_r.count = r.count - lpt_count_w'(lpt_pixel_cycles);
         end
         default: next_r.state = lpt_idle;
      endcase
      // axi write
      if (s_axi_awvalid && r.awready)
      begin
         next_r.aw_got = 1'b1;
         next_r.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && r.wready)
      begin
         next_r.w_got = 1'b1;
         next_r.wdata = s_axi_wdata;
         next_r.wstrb = s_axi_wstrb;
      end
      if (r.aw_got && r.w_got)
      begin
         next_r.aw_got = 1'b0;
         next_r.w_got = 1'b0;
         next_r.bvalid = 1'b1;
         next_r.bresp = lpt_resp_okay;
         unique case (r.awaddr)
            lpt_ctrl_off: next_r.ctrl = (r.ctrl & ~wmask) |
               (r.wdata & wmask);
            lpt_overlap_off:
               if (r.wstrb[0])
                  next_r.overlap = r.wdata[7:0];
            lpt_status_off: next_r.bresp = lpt_resp_okay;
            default: next_r.bresp = lpt_resp_slverr;
         endcase
      end
      if (r.bvalid && s_axi_bready)
         next_r.bvalid = 1'b0;
      // axi read
      next_r.arready = 1'b0;
      if (s_axi_arvalid && !r.arready && !r.rvalid)
      begin
         next_r.arready = 1'b1;
         next_r.rvalid = 1'b1;
         next_r.rresp = lpt_resp_okay;
         unique case (s_axi_araddr)
            lpt_ctrl_off: next_r.rdata = r.ctrl;
            lpt_overlap_off: next_r.rdata = {24'h000000, r.overlap};
            lpt_status_off: next_r.rdata = {16'h0000, r.count[11:0],
               r.entry_sel};
            default:
            begin
               next_r.rdata = 32'h00000000;
               next_r.rresp = lpt_resp_slverr;
            end
         endcase
         next_r.rdata[31:30] = (s_axi_araddr == lpt_status_off) ?
            r.state : next_r.rdata[31:30];
      end
      if (r.rvalid && s_axi_rready)
         next_r.rvalid = 1'b0;
      // readies from flops; low while a write is held or answered
      next_r.awready = !next_r.aw_got && !next_r.bvalid;
      next_r.wready = !next_r.w_got && !next_r.bvalid;
   end

   generate
      for (genvar i = 0; i < 4; i++)
      begin : g_mask
         assign wmask[8*i +: 8] = {8{r.wstrb[i]}};
      end
   endgenerate

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         r <= '0;
         r.state <= lpt_idle;
         r.ctrl <= lpt_ctrl_reset;
         r.overlap <= lpt_overlap_reset;
      end
      else if (clock_enable)
         r <= next_r;
   end

   assign s_axi_awready = r.awready;
   assign s_axi_wready = r.wready;
   assign s_axi_bvalid = r.bvalid;
   assign s_axi_bresp = r.bresp;
   assign s_axi_arready = r.arready;
   assign s_axi_rvalid = r.rvalid;
   assign s_axi_rdata = r.rdata;
   assign s_axi_rresp = r.rresp;
   assign pattern_bit = r.pattern;
   assign horizontal_gate = r.hgate;
   assign horizontal_binning = r.binning;
   assign line_done = r.done;
endmodule : lpt_seq

// >>> lpt_seq_chk.sv
// lpt_seq_chk: port assertions for the line pattern sequencer.
// assumes it is bound to lpt_seq and sees only its ports.
module lpt_seq_chk
   import lpt_pkg::*;
(
   // clock, reset, enable, trigger
   input wire logic clock,
   input wire logic reset,
   input wire logic clock_enable,
   input wire logic integration_done_trigger,
   // axi4-lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // sensor pattern outputs
   input wire logic [6:1] pattern_bit,
   input wire logic horizontal_gate,
   input wire logic horizontal_binning,
   input wire logic line_done
);
   default clocking dc @(posedge clock);
   endclocking
   default disable iff (reset);
   sequence s_both;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_refused;
      !s_axi_awready && !s_axi_wready;
   endsequence
   a_reset_quiet: assert property (disable iff (1'b0)
      reset |=> pattern_bit == 6'h00 && !horizontal_gate && !line_done)
      else $error("outputs not quiet after reset");
   a_done_pulse: assert property (line_done |=> !line_done)
      else $error("line done longer than one cycle");
   a_bin_gate: assert property (horizontal_binning |-> horizontal_gate)
      else $error("binning flag without horizontal gate");
   a_dump_no_gate: assert property (pattern_bit[6] |-> !horizontal_gate)
      else $error("horizontal gate during dump");
   a_unused_bits: assert property (!pattern_bit[2] && !pattern_bit[5])
      else $error("unused pattern bit driven");
   a_write_answer: assert property (s_both |=> s_refused ##1 s_axi_bvalid)
      else $error("write response out of step");
   a_bvalid_release: assert property (
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response not released");
   a_read_answer: assert property (
      s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
      |=> s_axi_arready && s_axi_rvalid)
      else $error("read answer late");
   a_err_zero: assert property (
      s_axi_rvalid && s_axi_rresp == lpt_resp_slverr |-> s_axi_rdata == 32'h0)
      else $error("error read carries data");
endmodule : lpt_seq_chk

bind lpt_seq lpt_seq_chk chk (.*);

// >>> lpt_ccd_model.sv
// lpt_ccd_model: sensor side, counts rows moved and lines read.
// assumes pattern bits and gate come straight from the sequencer.
module lpt_ccd_model
   import lpt_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // sensor drive
   input wire logic [6:1] pattern_bit,
   input wire logic horizontal_gate,
   // transfer counts
   output int rows_moved,
   output int lines_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic last_bit4;
   logic last_gate;
   always @(posedge clock)
   begin
      last_bit4 <= pattern_bit[4];
      last_gate <= horizontal_gate;
      if (reset)
      begin
         rows_moved <= 0;
         lines_out <= 0;
      end
      else
      begin
         // row steps toward the horizontal register unless dumped
         if (pattern_bit[4] && !last_bit4 && !pattern_bit[6])
            rows_moved <= rows_moved + 1;
         if (!horizontal_gate && last_gate)
            lines_out <= lines_out + 1;
      end
   end
endmodule : lpt_ccd_model

// >>> lpt_seq_test.sv
// lpt_seq_test: runs every default table and the register bus.
// assumes lpt_seq, lpt_ccd_model and the bound checker are compiled.
module lpt_seq_test
   import lpt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 0, reset = 1, clock_enable = 1, integration_done_trigger = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
   logic s_axi_bready = 1, s_axi_rready = 1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, horizontal_gate, horizontal_binning, line_done;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [6:1] pattern_bit;
   logic [31:0] ov[$], ol[$], ev[$], el[$];
   logic bin_seen;
   int rows_moved, lines_out, miscompares = 0, checks = 0, cyc = 0;
   // counts per entry, then gate/pattern value (gate 64, bit6 32 .. bit1 1)
   int cnt [9][10] = '{'{1, 1, 30, 1, 30, 1, 0, 0, 0, 0},
      '{1, 500, 1, 240, 1, 400, 1310, 0, 0, 0}, '{1, 0, 0, 0, 0, 0, 0, 0, 0, 0},
      '{1, 1, 30, 1, 30, 1, 30, 1, 30, 0}, '{1, 1, 198, 1, 199, 0, 0, 0, 0, 0},
      '{1, 0, 0, 0, 0, 0, 0, 0, 0, 0}, '{1, 25, 1, 25, 0, 0, 0, 0, 0, 0},
      '{10, 10, 25, 2, 0, 0, 0, 0, 0, 0}, '{20, 200, 20, 10, 1, 0, 0, 0, 0, 0}};
   int val [9][10] = '{'{0, 4, 12, 4, 0, 64, 0, 0, 0, 0},
      '{0, 4, 5, 13, 5, 4, 0, 0, 0, 0}, '{64, 0, 0, 0, 0, 0, 0, 0, 0, 0},
      '{0, 4, 12, 4, 0, 4, 12, 4, 64, 0}, '{32, 36, 44, 36, 32, 0, 0, 0, 0, 0},
      '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0}, '{0, 4, 5, 13, 0, 0, 0, 0, 0, 0},
      '{13, 5, 4, 0, 0, 0, 0, 0, 0, 0}, '{4, 0, 4, 12, 13, 0, 0, 0, 0, 0}};
   int rexp [9] = '{1, 1, 0, 2, 0, 0, 1, 1, 1};
   int lexp [9] = '{1, 0, 0, 1, 0, 0, 0, 0, 0};
   lpt_seq uut (.*);
   lpt_ccd_model ccd (.clock(clock), .reset(reset), .pattern_bit(pattern_bit),
      .horizontal_gate(horizontal_gate), .rows_moved(rows_moved),
      .lines_out(lines_out));
   always #20 clock = ~clock;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wrap_up;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         miscompares++;
         wrap_up();
      end
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
      logic ta, tw, tb;
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do
      begin
         @(negedge clock);
         ta = s_axi_awvalid & s_axi_awready;
         tw = s_axi_wvalid & s_axi_wready;
         tb = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge clock);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end
      while (tb !== 1'b1);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
      logic ta, tr;
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do
      begin
         @(negedge clock);
         ta = s_axi_arready;
         tr = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge clock);
         if (ta) s_axi_arvalid <= 1'b0;
      end
      while (tr !== 1'b1);
   endtask : rd
   task automatic strip(ref logic [31:0] v[$], ref logic [31:0] l[$]);
      while (v.size() > 0 && v[0] == 0)
      begin
         void'(v.pop_front());
         void'(l.pop_front());
      end
      while (v.size() > 0 && v[$] == 0)
      begin
         void'(v.pop_back());
         void'(l.pop_back());
      end
   endtask : strip
   // runs of gate/pattern values until the table end pulse
   task automatic cap;
      logic [6:0] s;
      ov = {};
      ol = {};
      bin_seen = 0;
      do
      begin
         @(negedge clock);
         s = {horizontal_gate, pattern_bit};
         bin_seen |= horizontal_binning;
         if (ov.size() > 0 && ov[$] === {25'h0, s}) ol[$]++;
         else
         begin
            ov.push_back({25'h0, s});
            ol.push_back(1);
         end
      end
      while (line_done !== 1'b1);
      strip(ov, ol);
   endtask : cap
   task automatic wait_idle;
      logic [31:0] d;
      logic [1:0] r;
      int n;
      n = 0;
      do
      begin
         rd(lpt_status_off, d, r);
         n++;
      end
      while (d[31:30] !== lpt_idle && n < 1000);
      chk(d[31:30], lpt_idle);
   endtask : wait_idle
   task automatic regs;
      logic [31:0] d;
      logic [1:0] r;
      rd(lpt_overlap_off, d, r);
      chk(d, {24'h0, lpt_overlap_reset});
      rd(lpt_ctrl_off, d, r);
      chk(d, lpt_ctrl_reset);
      wr(lpt_overlap_off, 32'h5A, r);
      rd(lpt_overlap_off, d, r);
      chk(d, 32'h5A);
      rd(8'h0C, d, r);
      chk(r, lpt_resp_slverr);
      chk(d, 32'h0);
      wr(8'h0C, 32'h1, r);
      chk(r, lpt_resp_slverr);
      wr(lpt_overlap_off, 32'h0, r);
      chk(r, lpt_resp_okay);
      $display("register test done");
   endtask : regs
   task automatic run_tab(input int t, input int dly);
      logic [1:0] r;
      int r0, l0, i;
      r0 = rows_moved;
      l0 = lines_out;
      ev = {};
      el = {};
      for (i = 0; cnt[t][i] != 0; i++)
         if (ev.size() > 0 && ev[$] == val[t][i]) el[$] += cnt[t][i] + 1;
         else
         begin
            ev.push_back(val[t][i]);
            el.push_back(cnt[t][i] + 1);
         end
      strip(ev, el);
      wr(lpt_overlap_off, dly, r);
      // phase two edges shift later by the overlap delay
      if (dly > 0)
      begin
         el[0] -= dly;
         el[2] += dly;
         el[3] -= dly;
      end
      fork
         wr(lpt_ctrl_off, (t << 4) | 1, r);
         cap();
      join
      chk(ov.size(), ev.size());
      for (i = 0; i < ev.size() && i < ov.size(); i++)
      begin
         chk(ov[i], ev[i]);
         if (i > 0 && i < ev.size() - 1) chk(ol[i], el[i]);
      end
      chk(bin_seen, t == 3);
      wr(lpt_ctrl_off, 0, r);
      wait_idle();
      chk(rows_moved - r0, rexp[t]);
      chk(lines_out - l0, lexp[t]);
      wr(lpt_overlap_off, 0, r);
      $display("table %0d delay %0d test done", t, dly);
   endtask : run_tab
   task automatic integ;
      logic [1:0] r;
      int n;
      fork
         wr(lpt_ctrl_off, 32'h21, r);
         cap();
      join
      chk(ov.size(), 1);
      chk(ov[0], 64);
      n = 0;
      repeat (30)
      begin
         @(negedge clock);
         if (line_done === 1'b1) n++;
      end
      chk(n > 3, 1'b1);
      @(posedge clock);
      integration_done_trigger <= 1'b1;
      wait_idle();
      integration_done_trigger <= 1'b0;
      wr(lpt_ctrl_off, 0, r);
      // repeat mode reruns the table until start is cleared
      wr(lpt_ctrl_off, 32'h53, r);
      n = 0;
      repeat (30)
      begin
         @(negedge clock);
         if (line_done === 1'b1) n++;
      end
      chk(n > 8, 1'b1);
      wr(lpt_ctrl_off, 0, r);
      wait_idle();
      n = 0;
      repeat (10)
      begin
         @(negedge clock);
         if (line_done === 1'b1) n++;
      end
      chk(n, 0);
      $display("integration test done");
   endtask : integ
   initial
   begin
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      regs();
      for (int t = 0; t < 9; t++)
         if (t != 2) run_tab(t, 0);
      run_tab(0, 1);
      integ();
      wrap_up();
   end
endmodule : lpt_seq_test
